// File: pkg/fhp_defines.svh
// constants for the floppy host register port: addresses, fields, reset values
//
// Notes on behaviour
// - field_a bits 4:2: 111 off, steps, 000 default
// - field_a starts at track zero, configurable
// - rate bit 6 enters manual low power
// - soft reset or data/status access wakes
// - rate bit 7 soft-resets, then self-clears
// - status readable anytime; poll before each byte
// - status bits 0-3 show seeking drives
// - bit 4 busy from first byte to end
// - bit 5 high in polled execution phase
// - bit 6 direction: one read, zero write
// - bit 7 request; no data access when low
// - all bytes pass through one data register
// - FIFO disabled after any reset; here resets only flush it and fifo_enable stays an input
// - command bytes bypass FIFO; flush at execution
// - overrun/underrun ends command; pad zeros; drain
// - host services FIFO within threshold time
// - first mode: only bit 7 driven
// - second mode: change, ones, rate, density
// - third mode: rate, noprecomp, dma, change
// - rate encoding; hardware reset gives 250K
// - config no-field_a bit; reserved bits zero
// - density output high at hardware reset
// - latest rate or config write wins
// - hardware reset loads rate register 02
`ifndef FHP_DEFINES_SVH
`define FHP_DEFINES_SVH

// ----------------------------------------
// i/o addresses
// ----------------------------------------
`define FHP_ADDR_RATE 10'h3f4
`define FHP_ADDR_STATUS 10'h3f4
`define FHP_ADDR_DATA 10'h3f5
`define FHP_ADDR_INPUT 10'h3f7
`define FHP_ADDR_CONFIG 10'h3f7

// ----------------------------------------
// rate register fields and reset values
// ----------------------------------------
`define FHP_RATE_SWRST 7
`define FHP_RATE_LOWPWR 6
`define FHP_RATE_PRE_HI 4
`define FHP_RATE_PRE_LO 2
`define FHP_CFG_NOPRE 2
`define FHP_RATE_RESET 8'h02
`define FHP_RATE_SEL_RESET 2'h2
`define FHP_RATE_1M 2'h3
`define FHP_RATE_500K 2'h0
`define FHP_PRE_OFF 3'h7
`define FHP_PRE_DEFAULT 3'h0
`define FHP_PRE_DEF_1M 3'h1
`define FHP_PRE_DEF_SLOW 3'h3
`define FHP_PRE_STEP_PS 41670
`define FHP_PRE_TRACK_RESET 8'h00
`define FHP_CFG_WMASK 8'h07

// ----------------------------------------
// data fifo
// ----------------------------------------
`define FHP_FIFO_DEPTH 5'h10
`define FHP_FIFO_OFF_DEPTH 5'h01

// ----------------------------------------
// host apb registers
// ----------------------------------------
`define FHP_APB_CMD 8'h00
`define FHP_APB_STAT 8'h04

`endif

// File: pkg/fhp_pkg.sv
// types of the floppy host register port: phases and compat modes for the device end, states for the host end
package fhp_pkg;

	typedef enum logic [1:0] {
		FHP_PH_IDLE = 2'b00,
		FHP_PH_CMD = 2'b01,
		FHP_PH_EXEC = 2'b10,
		FHP_PH_RESULT = 2'b11
	} fhp_phase_e;

	typedef enum logic [1:0] {
		FHP_CM_BIT7 = 2'b00,
		FHP_CM_FULL = 2'b01,
		FHP_CM_DMA = 2'b10
	} fhp_compat_e;

	typedef enum logic [2:0] {
		FHP_HS_IDLE = 3'b000,
		FHP_HS_POLL = 3'b001,
		FHP_HS_POLL_WAIT = 3'b010,
		FHP_HS_GO = 3'b011,
		FHP_HS_GO_WAIT = 3'b100
	} fhp_host_state_e;

endpackage : fhp_pkg

// File: pkg/fhp_if.sv
// byte-wide i/o bus between the host end and the controller register port
`timescale 1ns/1ps
`default_nettype none

interface fhp_if;
	logic [9:0] io_addr;
	logic io_rd;
	logic io_wr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic [7:0] io_rdata_oe;
	logic io_ack;

	modport device(input io_addr, input io_rd, input io_wr, input io_wdata,
		output io_rdata, output io_rdata_oe, output io_ack);
	modport host(output io_addr, output io_rd, output io_wr, output io_wdata,
		input io_rdata, input io_rdata_oe, input io_ack);
endinterface : fhp_if

`default_nettype wire

// File: hw/fhp_device.sv
// controller end: rate, status, data fifo, input and config registers
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defines.svh"

module fhp_device (
	input wire logic pclk,
	input wire logic presetn,
	fhp_if.device io,
	input wire fhp_pkg::fhp_compat_e compat_mode,
	input wire logic media_changed_cable,
	input wire logic dma_allow,
	input wire logic output_reg_reset,
	input wire fhp_pkg::fhp_phase_e phase,
	input wire logic exec_read,
	input wire logic polled_sel,
	input wire logic fifo_enable,
	input wire logic [3:0] fifo_threshold,
	input wire logic cfg_track_we,
	input wire logic [7:0] cfg_track,
	input wire logic [3:0] drive_seek_active,
	output logic to_core_valid,
	output logic [7:0] to_core_data,
	input wire logic to_core_ready,
	input wire logic from_core_valid,
	input wire logic [7:0] from_core_data,
	output logic from_core_ready,
	output logic soft_reset,
	output logic low_power,
	output logic [1:0] rate_select,
	output logic density_select_out,
	output logic [2:0] field_a_steps,
	output logic [7:0] field_a_track,
	output logic no_field_a,
	output logic dma_req,
	output logic overrun,
	output logic underrun
);
	import fhp_pkg::*;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire hit_rate = io.io_addr == `FHP_ADDR_RATE;
	wire hit_data = io.io_addr == `FHP_ADDR_DATA;
	wire hit_input = io.io_addr == `FHP_ADDR_INPUT;
	wire wr_rate = io.io_wr && hit_rate;
	wire wr_config = io.io_wr && hit_input;
	wire rd_status = io.io_rd && hit_rate;
	wire wr_data = io.io_wr && hit_data;
	wire rd_data = io.io_rd && hit_data;
	wire sw_reset_bit = wr_rate && io.io_wdata[`FHP_RATE_SWRST];
	// either reset source clears the transfer machinery, never the rate settings
	wire any_soft = sw_reset_bit || output_reg_reset;

	// ----------------------------------------
	// data path through one register / fifo
	// ----------------------------------------
	logic [7:0] mem [0:15];
	logic [3:0] wr_ptr;
	logic [3:0] rd_ptr;
	logic [4:0] count;
	fhp_phase_e prev_phase;

	wire in_exec = phase == FHP_PH_EXEC;
	// the fifo only opens up during execution; parameters and results use one slot
	wire fifo_on = in_exec && fifo_enable;
	wire [4:0] limit = fifo_on ? `FHP_FIFO_DEPTH : `FHP_FIFO_OFF_DEPTH;
	wire enter_exec = in_exec && (prev_phase != FHP_PH_EXEC);
	wire flush = enter_exec || any_soft;
	wire empty = count == 5'h00;
	wire full = count >= limit;
	wire dir_to_host = (phase == FHP_PH_RESULT) || (in_exec && exec_read);
	wire host_request = dir_to_host ? !empty : !full;
	wire host_push = wr_data && !dir_to_host && !full;
	wire host_pop = rd_data && dir_to_host && !empty;
	wire core_push = from_core_valid && from_core_ready;
	wire core_pop = to_core_valid && to_core_ready;
	wire do_push = host_push || core_push;
	wire do_pop = host_pop || core_pop;
	wire [7:0] push_byte = host_push ? io.io_wdata : from_core_data;
	wire [4:0] next_count = count + {4'h0, do_push} - {4'h0, do_pop};
	wire [4:0] thr = (fifo_threshold == 4'h0) ? 5'h01 : {1'b0, fifo_threshold};
	wire [4:0] room = limit - count;

	assign from_core_ready = dir_to_host && !full;
	assign to_core_valid = !dir_to_host && !empty;
	// a starved disk write is padded with zero bytes until the sector ends
	assign to_core_data = empty ? 8'h00 : mem[rd_ptr];
	assign dma_req = fifo_on ? (exec_read ? count >= thr : room >= thr) : (in_exec && host_request);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= 4'h0;
			rd_ptr <= 4'h0;
			count <= 5'h00;
		end else if (flush) begin
			wr_ptr <= 4'h0;
			rd_ptr <= 4'h0;
			count <= 5'h00;
		end else begin
			wr_ptr <= do_push ? wr_ptr + 4'h1 : wr_ptr;
			rd_ptr <= do_pop ? rd_ptr + 4'h1 : rd_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge pclk) begin
		if (do_push && !flush) begin
			mem[wr_ptr] <= push_byte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_phase <= FHP_PH_IDLE;
			overrun <= 1'b0;
			underrun <= 1'b0;
		end else begin
			prev_phase <= phase;
			// the core ends the command on either pulse
			overrun <= in_exec && exec_read && from_core_valid && full;
			underrun <= in_exec && !exec_read && to_core_ready && empty;
		end
	end

	// ----------------------------------------
	// rate, precompensation and config state
	// ----------------------------------------
	logic [2:0] field_a;
	wire [1:0] next_rate = io.io_wdata[1:0];
	wire rate_write = wr_rate || wr_config;
	wire next_dens = (next_rate == `FHP_RATE_1M) || (next_rate == `FHP_RATE_500K);
	wire wake = any_soft || rd_status || rd_data || wr_data;
	wire sleep = wr_rate && io.io_wdata[`FHP_RATE_LOWPWR];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			field_a <= 3'(`FHP_RATE_RESET >> `FHP_RATE_PRE_LO);
			rate_select <= `FHP_RATE_SEL_RESET;
			density_select_out <= 1'b1;
			no_field_a <= 1'b0;
			low_power <= 1'b0;
			soft_reset <= 1'b0;
			field_a_track <= `FHP_PRE_TRACK_RESET;
		end else begin
			// soft resets restore no defaults to rate, field_a or density; a bit 7 rate write still loads them from its byte
			if (wr_rate) begin
				field_a <= io.io_wdata[`FHP_RATE_PRE_HI:`FHP_RATE_PRE_LO];
			end
			if (rate_write) begin
				rate_select <= next_rate;
				density_select_out <= next_dens;
			end
			if (wr_config) begin
				no_field_a <= io.io_wdata[`FHP_CFG_NOPRE];
			end
			if (sleep) begin
				low_power <= 1'b1;
			end else if (wake) begin
				low_power <= 1'b0;
			end
			// only a pulse is kept, so the bit reads back as cleared on its own
			soft_reset <= any_soft;
			if (cfg_track_we) begin
				field_a_track <= cfg_track;
			end
		end
	end

	// 111 turns shifting off; 000 falls back on a per-rate default
	wire [2:0] pre_default = (rate_select == `FHP_RATE_1M) ? `FHP_PRE_DEF_1M : `FHP_PRE_DEF_SLOW;
	assign field_a_steps = (field_a == `FHP_PRE_OFF) ? 3'h0 :
		(field_a == `FHP_PRE_DEFAULT) ? pre_default : field_a;

	// ----------------------------------------
	// read-back paths
	// ----------------------------------------
	wire low_density_flag = !((rate_select == `FHP_RATE_1M) || (rate_select == `FHP_RATE_500K));
	wire polled_exec_flag = polled_sel && in_exec;
	wire cmd_busy = phase != FHP_PH_IDLE;
	wire [7:0] main_status = {host_request, dir_to_host, polled_exec_flag, cmd_busy,
		drive_seek_active};
	wire media_changed = !media_changed_cable;
	logic [7:0] input_byte;
	logic [7:0] input_oe;

	always_comb begin
		unique case (compat_mode)
			FHP_CM_BIT7: begin
				input_byte = {media_changed, 7'h00};
				input_oe = 8'h80;
			end
			FHP_CM_FULL: begin
				input_byte = {media_changed, 4'hf, rate_select, low_density_flag};
				input_oe = 8'hff;
			end
			FHP_CM_DMA: begin
				input_byte = {media_changed, 3'h0, dma_allow, no_field_a, rate_select};
				input_oe = 8'hff;
			end
			default: begin
				input_byte = 8'h00;
				input_oe = 8'hff;
			end
		endcase
	end

	wire [7:0] data_out = empty ? 8'h00 : mem[rd_ptr];
	wire [7:0] next_rdata = hit_rate ? main_status : hit_data ? data_out : hit_input ? input_byte : 8'h00;
	wire [7:0] next_oe = hit_input ? input_oe : 8'hff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io.io_rdata <= 8'h00;
			io.io_rdata_oe <= 8'h00;
			io.io_ack <= 1'b0;
		end else begin
			io.io_ack <= io.io_rd || io.io_wr;
			if (io.io_rd) begin
				io.io_rdata <= next_rdata;
				io.io_rdata_oe <= next_oe;
			end else begin
				io.io_rdata_oe <= 8'h00;
			end
		end
	end

endmodule : fhp_device

`default_nettype wire

// File: hw/fhp_host.sv
// host end: apb-controlled i/o cycle engine with optional status polling
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defines.svh"

module fhp_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fhp_if.host io
);
	import fhp_pkg::*;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	fhp_host_state_e state;
	logic is_read;
	logic [9:0] data_addr;
	logic [7:0] last_data;
	logic [7:0] last_oe;
	wire acc = psel && penable;
	wire hit_cmd = paddr == `FHP_APB_CMD;
	wire hit_stat = paddr == `FHP_APB_STAT;
	wire busy = state != FHP_HS_IDLE;
	// a new order while one is in flight is dropped; software must watch busy
	wire take_cmd = acc && pwrite && hit_cmd && !busy;
	wire [9:0] cmd_addr = pwdata[17:8];
	// reserved config bits are always sent as zero
	wire [7:0] cmd_data = (cmd_addr == `FHP_ADDR_CONFIG) ? (pwdata[7:0] & `FHP_CFG_WMASK) : pwdata[7:0];
	wire [31:0] stat_word = {7'h00, busy, last_oe, last_data, 8'h00};

	assign pready = 1'b1;
	assign pslverr = acc && !(hit_cmd || hit_stat);
	assign prdata = (psel && hit_stat && !pwrite) ? stat_word : 32'h0;

	// ----------------------------------------
	// i/o cycle engine
	// ----------------------------------------
	// status reply says the data byte may move in the wanted direction
	wire poll_ok = io.io_rdata[7] && (io.io_rdata[6] == is_read);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= FHP_HS_IDLE;
			is_read <= 1'b0;
			data_addr <= 10'h000;
			last_data <= 8'h00;
			last_oe <= 8'h00;
			io.io_addr <= 10'h000;
			io.io_wdata <= 8'h00;
			io.io_rd <= 1'b0;
			io.io_wr <= 1'b0;
		end else begin
			io.io_rd <= 1'b0;
			io.io_wr <= 1'b0;
			unique case (state)
				FHP_HS_IDLE: begin
					if (take_cmd) begin
						// a guarded order polls the status register, never the data byte
						io.io_addr <= pwdata[19] ? `FHP_ADDR_STATUS : cmd_addr;
						data_addr <= cmd_addr;
						io.io_wdata <= cmd_data;
						is_read <= pwdata[18];
						state <= pwdata[19] ? FHP_HS_POLL : FHP_HS_GO;
					end
				end
				FHP_HS_POLL: begin
					// polling before the data byte of a guarded order, also while draining reads
					io.io_rd <= 1'b1;
					state <= FHP_HS_POLL_WAIT;
				end
				FHP_HS_POLL_WAIT: begin
					if (io.io_ack) begin
						state <= poll_ok ? FHP_HS_GO : FHP_HS_POLL;
					end
				end
				FHP_HS_GO: begin
					io.io_addr <= data_addr;
					io.io_rd <= is_read;
					io.io_wr <= !is_read;
					state <= FHP_HS_GO_WAIT;
				end
				FHP_HS_GO_WAIT: begin
					if (io.io_ack) begin
						if (is_read) begin
							last_data <= io.io_rdata;
							last_oe <= io.io_rdata_oe;
						end
						state <= FHP_HS_IDLE;
					end
				end
			endcase
		end
	end

endmodule : fhp_host

`default_nettype wire

// File: dv/fhp_monitor.sv
// protocol checker for the i/o bus between host end and register port
`timescale 1ns/1ps
`default_nettype none

module fhp_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [9:0] io_addr,
	input wire logic io_rd,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] io_rdata_oe,
	input wire logic io_ack
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------
	// sequences
	// ----------------------------------------
	sequence rd_of(logic [9:0] a);
		io_rd && io_addr == a;
	endsequence
	sequence full_view(logic [9:0] a);
		rd_of(a) ##1 io_rdata_oe == 8'hff;
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_ack_one_late: assert property ((io_rd || io_wr) |=> io_ack)
		else $error("strobe not answered one cycle later");
	chk_ack_has_cause: assert property (io_ack |-> $past(io_rd || io_wr))
		else $error("answer without a strobe");
	chk_strobe_apart: assert property ((io_rd || io_wr) |=> !(io_rd || io_wr))
		else $error("strobes closer than two cycles");
	chk_one_dir: assert property (!(io_rd && io_wr))
		else $error("read and write strobe together");
	chk_status_oe: assert property (rd_of(10'h3f4) |=> io_rdata_oe == 8'hff)
		else $error("status byte not fully driven");
	chk_input_oe: assert property (rd_of(10'h3f7) |=> io_rdata_oe inside {8'h80, 8'hff})
		else $error("input register drive pattern wrong");
	chk_input_fill: assert property (full_view(10'h3f7) |-> io_rdata[6:3] == 4'hf || io_rdata[6:4] == 3'h0)
		else $error("input register fill bits wrong");
	chk_write_quiet: assert property (io_wr |=> io_rdata_oe == 8'h00)
		else $error("data bus driven on a write");
	chk_rdata_hold: assert property (!io_ack |-> $stable(io_rdata))
		else $error("read byte changed without a read");
	chk_cfg_reserved: assert property ((io_wr && io_addr == 10'h3f7) |-> io_wdata[7:3] == 5'h00)
		else $error("reserved config bits written as one");
endmodule : fhp_monitor

`default_nettype wire

// File: dv/floppy_host_register_port_bench.sv
// self-checking bench: host end and register port joined over the i/o bus
`timescale 1ns/1ps
`default_nettype none

module floppy_host_register_port_bench;
	import fhp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
	logic [7:0] paddr, q, fdata, tdata, trk, ctrk;
	logic [31:0] pwdata, prdata, r;
	fhp_compat_e cm;
	fhp_phase_e ph;
	logic cable, dal, orst, xrd, pol, fen, twe, trdy, fval, frdy, tval, srst, lowp, dens, nopre, dreq, ovr, unr, gd;
	logic [3:0] seek, thr_sel;
	logic [1:0] rsel;
	logic [2:0] steps;
	int errors, checked, sr_cnt;

	fhp_if bus ();
	fhp_host fhp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .io(bus.host));
	fhp_device fhp_device_i (.pclk(pclk), .presetn(presetn), .io(bus.device), .compat_mode(cm),
		.media_changed_cable(cable), .dma_allow(dal), .output_reg_reset(orst), .phase(ph), .exec_read(xrd),
		.polled_sel(pol), .fifo_enable(fen), .fifo_threshold(thr_sel), .cfg_track_we(twe), .cfg_track(ctrk),
		.drive_seek_active(seek), .to_core_valid(tval), .to_core_data(tdata), .to_core_ready(trdy),
		.from_core_valid(fval), .from_core_data(fdata), .from_core_ready(frdy), .soft_reset(srst),
		.low_power(lowp), .rate_select(rsel), .density_select_out(dens), .field_a_steps(steps),
		.field_a_track(trk), .no_field_a(nopre), .dma_req(dreq), .overrun(ovr), .underrun(unr));
	fhp_monitor fhp_monitor_i (.pclk(pclk), .presetn(presetn), .io_addr(bus.io_addr), .io_rd(bus.io_rd),
		.io_wr(bus.io_wr), .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata), .io_rdata_oe(bus.io_rdata_oe),
		.io_ack(bus.io_ack));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk) if (srst === 1'b1) sr_cnt++;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one i/o cycle, then wait until the engine is idle again
	task automatic io(input logic [9:0] a, input logic rd, input logic [7:0] d);
		apb(1'b1, 8'h00, {12'h0, gd, rd, a, d});
		do apb(1'b0, 8'h04, 32'h0); while (r[24] !== 1'b0);
		q = r[15:8];
	endtask : io
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk("rate", rsel, 2'h2);
		chk("density", dens, 1'b1);
		chk("steps", steps, 3'h3);
		chk("track", trk, 8'h00);
		io(10'h3f7, 1'b1, 8'h00);
		chk("input", q, 8'hfd);
		$display("test reset done");
	endtask : t_reset
	task automatic t_rates;
		for (int v = 0; v < 8; v++) begin
			io(10'h3f4, 1'b0, {3'h0, v[2:0], 2'h2});
			chk("steps", steps, (v == 7) ? 0 : (v == 0) ? 3 : v);
		end
		for (int v = 0; v < 4; v++) begin
			io(10'h3f4, 1'b0, {6'h0, v[1:0]});
			chk("rate", rsel, v);
			chk("density", dens, v == 0 || v == 3);
			if (v == 3) chk("steps", steps, 3'h1);
			io(10'h3f7, 1'b1, 8'h00);
			chk("input", q[2:0], {v[1:0], !(v == 0 || v == 3)});
		end
		$display("test rates done");
	endtask : t_rates
	task automatic t_config;
		io(10'h3f7, 1'b0, 8'hfd);
		chk("rate", rsel, 2'h1);
		chk("noprecomp", nopre, 1'b1);
		io(10'h3f4, 1'b0, 8'h1e);
		chk("rate", rsel, 2'h2);
		cm <= FHP_CM_DMA;
		dal <= 1'b1;
		cable <= 1'b1;
		io(10'h3f7, 1'b1, 8'h00);
		chk("input", q, 8'h0e);
		cm <= FHP_CM_BIT7;
		io(10'h3f7, 1'b1, 8'h00);
		chk("bit7", q[7], 1'b0);
		chk("drive", r[23:16], 8'h80);
		cm <= FHP_CM_FULL;
		cable <= 1'b0;
		$display("test config done");
	endtask : t_config
	task automatic t_power;
		int n0;
		io(10'h3f4, 1'b0, 8'h42);
		chk("lowpower", lowp, 1'b1);
		io(10'h3f4, 1'b1, 8'h00);
		chk("lowpower", lowp, 1'b0);
		io(10'h3f4, 1'b0, 8'h41);
		n0 = sr_cnt;
		io(10'h3f4, 1'b0, 8'h81);
		chk("lowpower", lowp, 1'b0);
		chk("resets", sr_cnt - n0, 1);
		chk("noprecomp", nopre, 1'b1);
		chk("density", dens, 1'b0);
		orst <= 1'b1;
		@(posedge pclk);
		orst <= 1'b0;
		twe <= 1'b1;
		ctrk <= 8'h28;
		@(posedge pclk);
		twe <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("resets", sr_cnt - n0, 2);
		chk("rate", rsel, 2'h1);
		chk("track", trk, 8'h28);
		$display("test power done");
	endtask : t_power
	task automatic t_status;
		ph <= FHP_PH_EXEC;
		pol <= 1'b1;
		xrd <= 1'b1;
		seek <= 4'ha;
		io(10'h3f4, 1'b1, 8'h00);
		chk("status", q[5:0], 6'h3a);
		ph <= FHP_PH_CMD;
		pol <= 1'b0;
		seek <= 4'h0;
		io(10'h3f4, 1'b1, 8'h00);
		chk("status", q, 8'h90);
		$display("test status done");
	endtask : t_status
	task automatic t_data;
		io(10'h3f5, 1'b0, 8'h5a);
		chk("core byte", {tval, tdata}, 9'h15a);
		io(10'h3f4, 1'b1, 8'h00);
		chk("request", q[7], 1'b0);
		trdy <= 1'b1;
		@(posedge pclk);
		trdy <= 1'b0;
		@(posedge pclk);
		chk("pad", {tval, tdata}, 9'h000);
		io(10'h3f5, 1'b0, 8'h33);
		ph <= FHP_PH_EXEC;
		xrd <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("flush", tval, 1'b0);
		ph <= FHP_PH_RESULT;
		fval <= 1'b1;
		fdata <= 8'hc3;
		do @(posedge pclk); while (frdy !== 1'b1);
		fval <= 1'b0;
		io(10'h3f4, 1'b1, 8'h00);
		chk("status", q[7:6], 2'h3);
		gd = 1'b1;
		io(10'h3f5, 1'b1, 8'h00);
		gd = 1'b0;
		chk("result", q, 8'hc3);
		io(10'h3f5, 1'b1, 8'h00);
		chk("empty", q, 8'h00);
		ph <= FHP_PH_IDLE;
		io(10'h3f4, 1'b1, 8'h00);
		chk("busy", q[4], 1'b0);
		$display("test data done");
	endtask : t_data
	task automatic t_fifo;
		fen <= 1'b1;
		thr_sel <= 4'h2;
		xrd <= 1'b1;
		ph <= FHP_PH_EXEC;
		@(posedge pclk);
		fval <= 1'b1;
		fdata <= 8'h11;
		@(posedge pclk);
		fdata <= 8'h22;
		@(posedge pclk);
		fval <= 1'b0;
		@(posedge pclk);
		chk("dma read", dreq, 1'b1);
		io(10'h3f5, 1'b1, 8'h00);
		chk("fifo byte", q, 8'h11);
		chk("dma low", dreq, 1'b0);
		fval <= 1'b1;
		repeat (18) @(posedge pclk);
		chk("overrun", ovr, 1'b1);
		fval <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("overrun end", ovr, 1'b0);
		ph <= FHP_PH_IDLE;
		@(posedge pclk);
		xrd <= 1'b0;
		ph <= FHP_PH_EXEC;
		repeat (2) @(posedge pclk);
		chk("dma write", dreq, 1'b1);
		trdy <= 1'b1;
		@(posedge pclk);
		trdy <= 1'b0;
		@(posedge pclk);
		chk("underrun", unr, 1'b1);
		ph <= FHP_PH_IDLE;
		fen <= 1'b0;
		$display("test fifo done");
	endtask : t_fifo
	task automatic t_hwreset;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("rate", rsel, 2'h2);
		chk("density", dens, 1'b1);
		chk("track", trk, 8'h00);
		presetn <= 1'b1;
		io(10'h3f4, 1'b1, 8'h00);
		chk("status", q, 8'h80);
		$display("test hwreset done");
	endtask : t_hwreset

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cable, dal, orst, xrd, pol, fen, twe, trdy, fval, fdata, ctrk, seek, thr_sel, gd} = '0;
		cm = FHP_CM_FULL;
		ph = FHP_PH_IDLE;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_rates;
		t_config;
		t_power;
		t_status;
		t_data;
		t_fifo;
		t_hwreset;
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped", se, 1'b1);
		tally_and_finish;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		tally_and_finish;
	end
endmodule : floppy_host_register_port_bench

`default_nettype wire
